// [design/smfc_defines.svh]
// constants for the serial mode, frame format and pin assignment block
// Operation
// - two-bit mode: 11 async8, 10 async7, 01 sync slave, 00 sync master
// - reset leaves the mode at sync master
// - sync frames are eight data bits, no start, stop or parity
// - sync master shifts on internal clock and drives it on the clock pin
// - sync slave shifts using the clock the external master supplies
// - only sync slave drives the ready pin, showing it can transfer
// - group select routes the four lines to port bits 0-3 or 4-7
// - reset selects the lower pin group
// - sync master leaves the ready line as general purpose I/O
// - async modes take only serial in and out; clock and ready stay I/O
// - async modes run only from the internal clock, never an external one
// - async frame: start, 7 or 8 data, optional parity, 1 or 2 stops
// - stop-length bit 1 gives two stop bits, 0 gives one
// - parity enable adds parity; type 1 odd, 0 even
// - reset leaves one stop bit and no parity
// - async transmitter and receiver shift separately, full duplex
// - async and sync master shift clock is timer output, dead while high-speed oscillator off
// - pins serve the interface only while serial enable is 1
// - sync master clock is timer output divided by sixteen
`ifndef SMFC_DEFINES_SVH
`define SMFC_DEFINES_SVH
`define SMFC_MODE_ASYNC8      2'h3
`define SMFC_MODE_ASYNC7      2'h2
`define SMFC_MODE_SLAVE       2'h1
`define SMFC_MODE_MASTER      2'h0
`define SMFC_RST_MODE         2'h0
`define SMFC_RST_GROUP        1'h0
`define SMFC_RST_STOP2        1'h0
`define SMFC_RST_PAR_EN       1'h0
`define SMFC_RST_PAR_ODD      1'h0
`define SMFC_DIV_LAST         4'hF
`define SMFC_HALF_LAST        4'h7
`define SMFC_SYNC_BITS        4'h8
`define SMFC_PIN_SIN          3'h0
`define SMFC_PIN_SERIAL_OUT_PIN         3'h1
`define SMFC_PIN_SCLK         3'h2
`define SMFC_PIN_RDY          3'h3
`define SMFC_UPPER_BASE       3'h4
`endif

// [design/smfc_pkg.sv]
// types for the serial mode, frame format and pin assignment block
package smfc_pkg;
  typedef enum logic [1:0] {
    SMFC_ASYNC8 = 2'h3,
    SMFC_ASYNC7 = 2'h2,
    SMFC_SLAVE  = 2'h1,
    SMFC_MASTER = 2'h0
  } smfc_mode_t;
  typedef enum {SMFC_RX_IDLE, SMFC_RX_START, SMFC_RX_BITS} smfc_rx_state_t;
endpackage

// [design/smfc_top.sv]
// serial interface mode, frame format, shifting and port pin assignment
`timescale 1ns/1ps
`include "smfc_defines.svh"
module smfc_top
  import smfc_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       resetn_in,
  input  wire logic       cfg_write_in,
  input  wire logic [1:0] transfer_mode_select_in,
  input  wire logic       pin_group_select_in,
  input  wire logic       stop_length_select_in,
  input  wire logic       parity_enable_in,
  input  wire logic       parity_type_select_in,
  input  wire logic       serial_enable_in,
  input  wire logic       high_speed_oscillator_in,
  input  wire logic       timer_tick_in,
  input  wire logic       tx_valid_in,
  input  wire logic [7:0] tx_data_in,
  output logic            tx_ready_out,
  output logic            rx_valid_out,
  input  wire logic       rx_ready_in,
  output logic [7:0]      rx_data_out,
  output logic            rx_parity_err_out,
  output logic            rx_frame_err_out,
  output logic [1:0]      transfer_mode_out,
  output logic            pin_group_out,
  input  wire logic [7:0] port_pins_in,
  input  wire logic [7:0] gpio_out_in,
  input  wire logic [7:0] gpio_oe_n_in,
  output logic [7:0]      port_pins_out,
  output logic [7:0]      port_pins_oe_n_out
);
  // configuration
  logic [1:0] mode, next_mode;
  logic       group, next_group;
  logic       stop2, next_stop2;
  logic       par_en, next_par_en;
  logic       par_odd, next_par_odd;

  always_comb begin
    next_mode    = mode;
    next_group   = group;
    next_stop2   = stop2;
    next_par_en  = par_en;
    next_par_odd = par_odd;
    if (cfg_write_in) begin
      next_mode    = transfer_mode_select_in;
      next_group   = pin_group_select_in;
      next_stop2   = stop_length_select_in;
      next_par_en  = parity_enable_in;
      next_par_odd = parity_type_select_in;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      mode    <= `SMFC_RST_MODE;
      group   <= `SMFC_RST_GROUP;
      stop2   <= `SMFC_RST_STOP2;
      par_en  <= `SMFC_RST_PAR_EN;
      par_odd <= `SMFC_RST_PAR_ODD;
    end else begin
      mode    <= next_mode;
      group   <= next_group;
      stop2   <= next_stop2;
      par_en  <= next_par_en;
      par_odd <= next_par_odd;
    end
  end

  assign transfer_mode_out = mode;
  assign pin_group_out     = group;

  // decoded setup
  logic       is_async, is_master, is_slave, seven;
  logic [3:0] nbits, rx_k;
  logic [2:0] base;
  logic       tick, si, sclk_pin;
  assign is_async  = mode[1];
  assign is_master = (mode == `SMFC_MODE_MASTER);
  assign is_slave  = (mode == `SMFC_MODE_SLAVE);
  assign seven     = (mode == `SMFC_MODE_ASYNC7);
  assign nbits     = seven ? 4'h7 : 4'h8;
  assign rx_k      = nbits + {3'h0, par_en} + 4'h1;
  assign base      = group ? `SMFC_UPPER_BASE : 3'h0;
  // no timer clock reaches the shifter while the oscillator is off
  assign tick      = timer_tick_in & high_speed_oscillator_in & serial_enable_in;
  assign si        = port_pins_in[base + `SMFC_PIN_SIN];
  assign sclk_pin  = port_pins_in[base + `SMFC_PIN_SCLK];

  // shifting engine and receive buffer
  logic [11:0] tx_sh, next_tx_sh;
  logic [3:0]  tx_left, next_tx_left;
  logic [3:0]  tx_phase, next_tx_phase;
  logic [9:0]  rx_sh, next_rx_sh;
  logic [3:0]  rx_left, next_rx_left;
  logic [3:0]  rx_phase, next_rx_phase;
  smfc_rx_state_t rx_state, next_rx_state;
  logic        sclk_prev, next_sclk_prev;
  logic [9:0]  buf_mem [2];
  logic [9:0]  next_buf_mem [2];
  logic        buf_rd, next_buf_rd;
  logic [1:0]  buf_cnt, next_buf_cnt;

  logic        tx_idle, buf_room, load, push, pop;
  logic [9:0]  push_word;
  logic [9:0]  shifted, aligned;
  logic [7:0]  rdata;
  logic        pbit, rise, fall;

  assign tx_idle  = (tx_left == 4'h0);
  // a sync frame receives while it sends, so it needs a free slot first
  assign buf_room = (buf_cnt != 2'h2);
  assign load     = serial_enable_in & tx_idle & tx_valid_in &
                    (is_async | buf_room);
  assign tx_ready_out = serial_enable_in & tx_idle & (is_async | buf_room);
  assign rise     = ~sclk_prev & sclk_pin;
  assign fall     = sclk_prev & ~sclk_pin;
  assign pop      = rx_valid_out & rx_ready_in;

  always_comb begin
    next_tx_sh    = tx_sh;
    next_tx_left  = tx_left;
    next_tx_phase = tx_phase;
    next_rx_sh    = rx_sh;
    next_rx_left  = rx_left;
    next_rx_phase = rx_phase;
    next_rx_state = rx_state;
    next_sclk_prev = sclk_pin;
    push      = 1'b0;
    push_word = 10'h000;
    shifted   = {si, rx_sh[9:1]};
    aligned   = shifted >> (4'hA - rx_k);
    rdata     = seven ? {1'b0, aligned[6:0]} : aligned[7:0];
    pbit      = aligned[nbits];
    // transmitter
    if (load) begin
      next_tx_phase = 4'h0;
      if (is_async) begin
        next_tx_sh = 12'hFFF;
        next_tx_sh[0] = 1'b0;
        for (int i = 0; i < 8; i++) begin
          if (i < int'(nbits)) begin
            next_tx_sh[i + 1] = tx_data_in[i];
          end
        end
        if (par_en) begin
          next_tx_sh[nbits + 4'h1] = (^(seven ? {1'b0, tx_data_in[6:0]} : tx_data_in))
                                     ^ par_odd;
        end
        next_tx_left = nbits + {3'h0, par_en} + (stop2 ? 4'h3 : 4'h2);
      end else begin
        next_tx_sh   = {4'hF, tx_data_in};
        next_tx_left = `SMFC_SYNC_BITS;
        next_rx_sh   = 10'h000;
      end
    end else if (!tx_idle) begin
      if (is_slave) begin
        if (rise) begin
          next_rx_sh   = {2'h0, si, rx_sh[7:1]};
          next_tx_left = tx_left - 4'h1;
          if (tx_left == 4'h1) begin
            push      = 1'b1;
            push_word = {2'h0, si, rx_sh[7:1]};
          end
        end else if (fall && tx_left != `SMFC_SYNC_BITS) begin
          next_tx_sh = {1'b1, tx_sh[11:1]};
        end
      end else if (tick) begin
        next_tx_phase = tx_phase + 4'h1;
        if (!is_async && tx_phase == `SMFC_HALF_LAST) begin
          next_rx_sh = {2'h0, si, rx_sh[7:1]};
        end
        if (tx_phase == `SMFC_DIV_LAST) begin
          next_tx_sh   = {1'b1, tx_sh[11:1]};
          next_tx_left = tx_left - 4'h1;
          // last bit was sampled at mid-bit, so rx_sh is whole here
          if (!is_async && tx_left == 4'h1) begin
            push      = 1'b1;
            push_word = rx_sh;
          end
        end
      end
    end
    // asynchronous receiver, internal clock only
    case (rx_state)
      SMFC_RX_IDLE: begin
        // holding off while the buffer is full drops the incoming word, so a stored word is not overwritten
        if (is_async && tick && !si && buf_room) begin
          next_rx_state = SMFC_RX_START;
          next_rx_phase = 4'h0;
        end
      end
      SMFC_RX_START: begin
        if (!is_async) begin
          next_rx_state = SMFC_RX_IDLE;
        end else if (tick) begin
          next_rx_phase = rx_phase + 4'h1;
          if (rx_phase == `SMFC_HALF_LAST) begin
            next_rx_phase = 4'h0;
            next_rx_left  = rx_k;
            // line high again at mid-bit means noise, so go back to hunting
            next_rx_state = si ? SMFC_RX_IDLE : SMFC_RX_BITS;
          end
        end
      end
      SMFC_RX_BITS: begin
        if (!is_async) begin
          next_rx_state = SMFC_RX_IDLE;
        end else if (tick) begin
          next_rx_phase = rx_phase + 4'h1;
          if (rx_phase == `SMFC_DIV_LAST) begin
            next_rx_sh   = shifted;
            next_rx_left = rx_left - 4'h1;
            if (rx_left == 4'h1) begin
              next_rx_state = SMFC_RX_IDLE;
              push      = 1'b1;
              push_word = {~si, par_en & (pbit != ((^rdata) ^ par_odd)), rdata};
            end
          end
        end
      end
      default: next_rx_state = SMFC_RX_IDLE;
    endcase
    // two-entry receive buffer
    next_buf_mem = buf_mem;
    next_buf_rd  = buf_rd;
    next_buf_cnt = buf_cnt;
    if (pop) begin
      next_buf_rd = ~buf_rd;
    end
    if (push) begin
      next_buf_mem[buf_rd ^ buf_cnt[0]] = push_word;
    end
    next_buf_cnt = buf_cnt + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tx_sh      <= 12'hFFF;
      tx_left    <= 4'h0;
      tx_phase   <= 4'h0;
      rx_sh      <= 10'h000;
      rx_left    <= 4'h0;
      rx_phase   <= 4'h0;
      rx_state   <= SMFC_RX_IDLE;
      // clock pin idles high, so no false edge right after reset
      sclk_prev  <= 1'b1;
      buf_mem[0] <= 10'h000;
      buf_mem[1] <= 10'h000;
      buf_rd     <= 1'b0;
      buf_cnt    <= 2'h0;
    end else begin
      tx_sh      <= next_tx_sh;
      tx_left    <= next_tx_left;
      tx_phase   <= next_tx_phase;
      rx_sh      <= next_rx_sh;
      rx_left    <= next_rx_left;
      rx_phase   <= next_rx_phase;
      rx_state   <= next_rx_state;
      sclk_prev  <= next_sclk_prev;
      buf_mem    <= next_buf_mem;
      buf_rd     <= next_buf_rd;
      buf_cnt    <= next_buf_cnt;
    end
  end

  assign rx_valid_out      = (buf_cnt != 2'h0);
  assign rx_data_out       = buf_mem[buf_rd][7:0];
  assign rx_parity_err_out = buf_mem[buf_rd][8];
  assign rx_frame_err_out  = buf_mem[buf_rd][9];

  // pin takeover
  always_comb begin
    port_pins_out      = gpio_out_in;
    port_pins_oe_n_out = gpio_oe_n_in;
    if (serial_enable_in) begin
      port_pins_oe_n_out[base + `SMFC_PIN_SIN] = 1'b1;
      port_pins_out[base + `SMFC_PIN_SIN]      = 1'b0;
      port_pins_oe_n_out[base + `SMFC_PIN_SERIAL_OUT_PIN] = 1'b0;
      port_pins_out[base + `SMFC_PIN_SERIAL_OUT_PIN]      = tx_idle | tx_sh[0];
      if (is_master) begin
        // low half of each bit period, idle high
        port_pins_oe_n_out[base + `SMFC_PIN_SCLK] = 1'b0;
        port_pins_out[base + `SMFC_PIN_SCLK]      = tx_idle | tx_phase[3];
        // ready line unused here, left to the port
        port_pins_oe_n_out[base + `SMFC_PIN_RDY]  = gpio_oe_n_in[base + `SMFC_PIN_RDY];
        port_pins_out[base + `SMFC_PIN_RDY]       = gpio_out_in[base + `SMFC_PIN_RDY];
      end else if (is_slave) begin
        port_pins_oe_n_out[base + `SMFC_PIN_SCLK] = 1'b1;
        port_pins_out[base + `SMFC_PIN_SCLK]      = 1'b0;
        port_pins_oe_n_out[base + `SMFC_PIN_RDY]  = 1'b0;
        port_pins_out[base + `SMFC_PIN_RDY]       = tx_idle;
      end else begin
        // async leaves clock and ready lines with the port logic
        port_pins_oe_n_out[base + `SMFC_PIN_SCLK] = gpio_oe_n_in[base + `SMFC_PIN_SCLK];
        port_pins_oe_n_out[base + `SMFC_PIN_RDY]  = gpio_oe_n_in[base + `SMFC_PIN_RDY];
      end
    end
  end
endmodule

// [verif/smfc_peer.sv]
// far-side device: echoes serial out to serial in, clocks a slave frame on request
`timescale 1ns/1ps
module smfc_peer (
  input  wire logic       clk_in,
  input  wire logic       burst_in,
  input  wire logic [7:0] pins_out_in,
  input  wire logic [7:0] pins_oe_n_in,
  output logic      [7:0] pins_level_out
);
  logic [7:0] lvl;
  logic [6:0] cnt = 7'h00;
  logic       sclk;
  // released lines go to the pull-up, never a stale value
  assign lvl  = pins_out_in | pins_oe_n_in;
  // eight pulses of eight cycles each; the clock stands high between frames
  assign sclk = (cnt == 7'h00) | ~cnt[2];
  always @(posedge clk_in) begin
    if (burst_in && cnt == 7'h00) begin
      cnt <= 7'h40;
    end else if (cnt != 7'h00) begin
      cnt <= cnt - 7'h01;
    end
  end
  always_comb begin
    pins_level_out    = lvl;
    pins_level_out[0] = lvl[1];
    pins_level_out[2] = lvl[2] & sclk;
    pins_level_out[4] = lvl[5];
    pins_level_out[6] = lvl[6] & sclk;
  end
endmodule

// [verif/smfc_props.sv]
// checker: config readback, pin routing per mode, tx start bit
`timescale 1ns/1ps
module smfc_props (
  input wire logic       clk_in,
  input wire logic       resetn_in,
  input wire logic       cfg_write_in,
  input wire logic [1:0] transfer_mode_select_in,
  input wire logic       pin_group_select_in,
  input wire logic       serial_enable_in,
  input wire logic       tx_valid_in,
  input wire logic       tx_ready_out,
  input wire logic       rx_valid_out,
  input wire logic [1:0] transfer_mode_out,
  input wire logic       pin_group_out,
  input wire logic [7:0] gpio_oe_n_in,
  input wire logic [7:0] port_pins_oe_n_out,
  input wire logic [7:0] gpio_out_in,
  input wire logic [7:0] port_pins_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  logic [2:0] b;
  logic [1:0] m;
  logic       en;
  assign b  = {pin_group_out, 2'h0};
  assign m  = transfer_mode_out;
  assign en = serial_enable_in;
  a_mode_load: assert property (cfg_write_in |=> m == $past(transfer_mode_select_in))
    else $error("mode readback");
  a_group_load: assert property (cfg_write_in |=> b[2] == $past(pin_group_select_in))
    else $error("group readback");
  a_off_gpio: assert property (!en |-> port_pins_out == gpio_out_in)
    else $error("pins not released");
  a_async_gpio: assert property (en && m[1] |-> port_pins_oe_n_out[b+2] == gpio_oe_n_in[b+2]
    && port_pins_oe_n_out[b+3] == gpio_oe_n_in[b+3]) else $error("async took clk or ready");
  a_master_pins: assert property (en && m == 2'h0 |-> !port_pins_oe_n_out[b+2]
    && port_pins_oe_n_out[b+3] == gpio_oe_n_in[b+3]) else $error("master pins");
  a_slave_pins: assert property (en && m == 2'h1 |-> !port_pins_oe_n_out[b+3]
    && port_pins_oe_n_out[b+2]) else $error("slave pins");
  a_serial_lines: assert property (en |-> !port_pins_oe_n_out[b+1] && port_pins_oe_n_out[b])
    else $error("serial lines");
  a_start_bit: assert property (en && m[1] && tx_valid_in && tx_ready_out
    |=> !en || !port_pins_out[b+1]) else $error("no start bit");
  c_async_rx: cover property (en && m[1] && rx_valid_out);
  c_slave_load: cover property (en && m == 2'h1 && tx_valid_in && tx_ready_out);
  c_off: cover property (!en);
  c_sync_rx: cover property (en && !m[1] && rx_valid_out);
endmodule

bind smfc_top smfc_props u_props (.clk_in, .resetn_in, .cfg_write_in, .transfer_mode_select_in,
  .pin_group_select_in, .serial_enable_in, .tx_valid_in, .tx_ready_out, .rx_valid_out,
  .transfer_mode_out, .pin_group_out, .gpio_oe_n_in, .port_pins_oe_n_out, .gpio_out_in,
  .port_pins_out);

// [verif/tb.sv]
// bench: reset values, pin release, async, sync and buffer traffic
`timescale 1ns/1ps
module tb;
  logic       clk_in = 1'h0, resetn_in = 1'h0, cfg_write_in = 1'h0, timer_tick_in = 1'h0;
  logic       pin_group_select_in = 1'h0, stop_length_select_in = 1'h0;
  logic       parity_enable_in = 1'h0, parity_type_select_in = 1'h0, rx_ready_in = 1'h0;
  logic       serial_enable_in = 1'h1, high_speed_oscillator_in = 1'h1, tx_valid_in = 1'h0;
  logic       tx_ready_out, rx_valid_out, rx_parity_err_out, rx_frame_err_out, pin_group_out;
  logic [1:0] transfer_mode_select_in = 2'h0, transfer_mode_out, div = 2'h0;
  logic [7:0] tx_data_in = 8'h00, gpio_out_in = 8'h5A, gpio_oe_n_in = 8'hC3;
  logic [7:0] rx_data_out, port_pins_in, port_pins_out, port_pins_oe_n_out;
  logic       peer_burst = 1'h0;
  int         err_count = 0, check_count = 0;

  smfc_top dut (.clk_in, .resetn_in, .cfg_write_in, .transfer_mode_select_in,
    .pin_group_select_in, .stop_length_select_in, .parity_enable_in, .parity_type_select_in,
    .serial_enable_in, .high_speed_oscillator_in, .timer_tick_in, .tx_valid_in, .tx_data_in,
    .tx_ready_out, .rx_valid_out, .rx_ready_in, .rx_data_out, .rx_parity_err_out,
    .rx_frame_err_out, .transfer_mode_out, .pin_group_out, .port_pins_in, .gpio_out_in,
    .gpio_oe_n_in, .port_pins_out, .port_pins_oe_n_out);
  smfc_peer peer (.clk_in, .burst_in(peer_burst), .pins_out_in(port_pins_out),
    .pins_oe_n_in(port_pins_oe_n_out), .pins_level_out(port_pins_in));

  always #50 clk_in = ~clk_in;
  always @(negedge clk_in) begin
    div <= div + 2'h1;
    timer_tick_in <= (div == 2'h3);
  end

  task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic await(input logic rx);
    int i;
    for (i = 0; i < 3000; i++) begin
      if ((rx ? rx_valid_out : tx_ready_out) === 1'h1) break;
      @(negedge clk_in);
    end
    if (i == 3000) begin
      check("wait", 8'h00, 8'h01);
      final_report();
    end
  endtask
  task automatic rst();
    resetn_in = 1'h0;
    repeat (5) @(negedge clk_in);
    resetn_in = 1'h1;
    @(negedge clk_in);
  endtask
  task automatic cfg(input logic [1:0] m, input logic [2:0] f, input logic g);
    transfer_mode_select_in = m;
    {stop_length_select_in, parity_enable_in, parity_type_select_in} = f;
    pin_group_select_in = g;
    cfg_write_in = 1'h1;
    @(negedge clk_in);
    cfg_write_in = 1'h0;
    check("mode", {6'h00, transfer_mode_out}, {6'h00, m});
    check("group", {7'h00, pin_group_out}, {7'h00, g});
  endtask
  task automatic send(input logic [7:0] d);
    tx_data_in = d;
    tx_valid_in = 1'h1;
    await(1'h0);
    @(negedge clk_in);
    tx_valid_in = 1'h0;
    @(negedge clk_in);
  endtask
  task automatic recv(input logic [7:0] d);
    await(1'h1);
    check("rx data", rx_data_out, d);
    check("rx errs", {6'h00, rx_frame_err_out, rx_parity_err_out}, 8'h00);
    rx_ready_in = 1'h1;
    @(negedge clk_in);
    rx_ready_in = 1'h0;
    @(negedge clk_in);
  endtask
  task automatic frame_len(output int n, output int rises);
    logic c;
    n = 0;
    rises = 0;
    while (n < 1000 && tx_ready_out !== 1'h1) begin
      c = port_pins_out[2];
      @(negedge clk_in);
      n++;
      if (!c && port_pins_out[2]) rises++;
    end
  endtask

  task automatic t_reset();
    rst();
    check("mode", {6'h00, transfer_mode_out}, 8'h00);
    check("group", {7'h00, pin_group_out}, 8'h00);
    check("idle out, clk", {6'h00, port_pins_out[2:1]}, 8'h03);
    serial_enable_in = 1'h0;
    @(negedge clk_in);
    check("pins off", port_pins_oe_n_out, gpio_oe_n_in);
    serial_enable_in = 1'h1;
    $display("done reset");
  endtask
  task automatic t_async8();
    int n, r;
    cfg(2'h3, 3'h6, 1'h1);
    send(8'hA5);
    check("start", {7'h00, port_pins_out[5]}, 8'h00);
    check("lower free", {7'h00, port_pins_oe_n_out[1]}, {7'h00, gpio_oe_n_in[1]});
    frame_len(n, r);
    check("async8 frame", {7'h00, (n > 760) && (n < 770)}, 8'h01);
    recv(8'hA5);
    await(1'h0);
    $display("done async8");
  endtask
  task automatic t_async7();
    cfg(2'h2, 3'h3, 1'h0);
    high_speed_oscillator_in = 1'h0;
    send(8'hC3);
    repeat (100) @(negedge clk_in);
    check("frozen", {7'h00, port_pins_out[1]}, 8'h00);
    high_speed_oscillator_in = 1'h1;
    recv(8'h43);
    await(1'h0);
    $display("done async7");
  endtask
  task automatic t_buffer();
    cfg(2'h3, 3'h0, 1'h0);
    send(8'h11);
    send(8'h22);
    send(8'h33);
    await(1'h0);
    recv(8'h11);
    recv(8'h22);
    check("third dropped", {7'h00, rx_valid_out}, 8'h00);
    $display("done buffer");
  endtask
  task automatic t_master();
    int n, r;
    cfg(2'h0, 3'h7, 1'h0);
    send(8'h96);
    check("master clk low", {7'h00, port_pins_out[2]}, 8'h00);
    frame_len(n, r);
    check("master edges", r[7:0], 8'h08);
    check("master frame", {7'h00, (n > 500) && (n < 520)}, 8'h01);
    recv(8'h96);
    await(1'h0);
    $display("done master");
  endtask
  task automatic t_slave();
    cfg(2'h1, 3'h0, 1'h0);
    check("ready idle", {7'h00, port_pins_out[3]}, 8'h01);
    send(8'h6B);
    check("ready low", {7'h00, port_pins_out[3]}, 8'h00);
    check("bit0", {7'h00, port_pins_out[1]}, 8'h01);
    peer_burst = 1'h1;
    @(negedge clk_in);
    peer_burst = 1'h0;
    recv(8'h6B);
    check("ready back", {7'h00, port_pins_out[3]}, 8'h01);
    rst();
    check("mode again", {6'h00, transfer_mode_out}, 8'h00);
    check("ready as port", {7'h00, port_pins_oe_n_out[3]}, {7'h00, gpio_oe_n_in[3]});
    $display("done slave");
  endtask

  initial begin
    t_reset();
    t_async8();
    t_async7();
    t_buffer();
    t_master();
    t_slave();
    final_report();
  end
endmodule
